// File: core/ersc_pkg.sv
package ersc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_EXC_CFG   = 12'h000;  // exception_config_reset_ctrl
  localparam logic [11:0] ADDR_LOW_POWER = 12'h004;  // low_power_entry_ctrl

  // ----------------------------------------------------------------------
  // Field positions and constants
  // ----------------------------------------------------------------------
  localparam logic [15:0] UNLOCK_KEY_VALUE      = 16'h05FA;
  localparam logic [15:0] UNLOCK_READBACK_VALUE = 16'hFA05;
  localparam int          KEY_LSB               = 16;
  localparam int          ENDIAN_BIT            = 15;
  localparam int          SPLIT_LSB             = 8;
  localparam int          RESET_REQ_BIT         = 2;
  localparam int          WAKE_ANY_BIT          = 4;
  localparam int          DEPTH_BIT             = 2;
  localparam int          NAP_BIT               = 1;
  localparam logic [2:0]  SPLIT_RESET           = 3'h0;
  localparam logic        ENDIAN_LITTLE         = 1'b0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       wake_on_any_pending;
    logic       low_power_depth_select;
    logic       nap_after_last_handler;
  } ersc_lp_type;

  typedef struct packed {
    logic [7:0] prio_a;
    logic [7:0] prio_b;
  } ersc_prio_pair_type;

  typedef enum logic [1:0] {
    ERSC_RUN   = 2'b00,
    ERSC_WAIT  = 2'b01,
    ERSC_SLEEP = 2'b11
  } ersc_state_type;

endpackage

// File: core/ersc_preempt.sv
`timescale 1ns/1ps
// Group priority comparator: a wins preemption only on a strictly lower group value.
module ersc_preempt
  import ersc_pkg::*;
(
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire logic [2:0]         split,
  input  wire ersc_prio_pair_type pair,
  output logic                    preempt
);

  logic [7:0] mask;
  logic [7:0] grp_a;
  logic [7:0] grp_b;

  // ----------------------------------------------------------------------
  // Group mask
  // ----------------------------------------------------------------------
  // group bits split
  always_comb begin
    mask = 8'hFF << (split + 3'h1);
    if (split == 3'h7) begin
      mask = 8'h00;
    end
  end

  assign grp_a = pair.prio_a & mask;
  assign grp_b = pair.prio_b & mask;

  // Registered so the comparison result is a flop output.
  // group only compare
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      preempt <= 1'b0;
    end else begin
      preempt <= (grp_a < grp_b);
    end
  end

  a_preempt_group: assert property (@(posedge CLK) disable iff (!RST_N)
    (split == 3'h7) |=> !preempt)
    else $error("preempt with single group");

  a_preempt_sub: assert property (@(posedge CLK) disable iff (!RST_N)
    (grp_a == grp_b) |=> !preempt)
    else $error("subpriority caused preemption");

endmodule

// File: core/ersc_top.sv
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module ersc_top
  import ersc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [7:0]  PRIO_A,
  input  wire logic [7:0]  PRIO_B,
  output logic             PREEMPT,
  input  wire logic        IRQ_PEND_ENABLED,
  input  wire logic        IRQ_PEND_DISABLED,
  input  wire logic        EVENT_PULSE,
  input  wire logic        EXT_EVENT,
  input  wire logic        SEND_EVENT_INSTR,
  input  wire logic        WAIT_FOR_EVENT_INSTR,
  input  wire logic        LAST_HANDLER_RETURN,
  output logic             WHOLE_SYSTEM_RESET_REQUEST,
  output logic             CORE_WAITING,
  output logic             CORE_SLEEP,
  output logic             CORE_DEEP_SLEEP
);

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic           wr_en;
  logic           rd_en;
  logic           hit_exc;
  logic           hit_lp;
  logic           key_ok;
  logic [2:0]     priority_split_point;
  ersc_lp_type    lp;
  logic           ext_meta;
  logic           ext_sync;
  logic           ext_prev;
  logic           ext_rise;
  logic           event_latch;
  logic           wake_src;
  logic           next_latch;
  ersc_state_type state;
  ersc_state_type next_state;
  logic [31:0]    next_rdata;
  ersc_prio_pair_type prio_pair;

  // Zero-wait slave: every access completes in its first access cycle.
  assign PREADY  = 1'b1;
  assign hit_exc = (PADDR == ADDR_EXC_CFG);
  assign hit_lp  = (PADDR == ADDR_LOW_POWER);
  // Unmapped addresses answer with an error instead of silently passing.
  assign PSLVERR = PSEL & PENABLE & ~(hit_exc | hit_lp);
  assign wr_en   = PSEL & PENABLE & PWRITE;
  assign rd_en   = PSEL & ~PENABLE & ~PWRITE;
  assign key_ok  = (PWDATA[31:KEY_LSB] == UNLOCK_KEY_VALUE);

  // ----------------------------------------------------------------------
  // Exception configuration register
  // ----------------------------------------------------------------------
  // key gated write
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      priority_split_point <= SPLIT_RESET;
    end else if (wr_en && hit_exc && key_ok) begin
      priority_split_point <= PWDATA[SPLIT_LSB +: 3];
    end
  end

  // The request is a one-cycle pulse; the reset controller stretches it.
  // reset request pulse
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      WHOLE_SYSTEM_RESET_REQUEST <= 1'b0;
    end else begin
      WHOLE_SYSTEM_RESET_REQUEST <= wr_en & hit_exc & key_ok & PWDATA[RESET_REQ_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Low-power control register
  // ----------------------------------------------------------------------
  // reserved writes dropped
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lp <= '0;
    end else if (wr_en && hit_lp) begin
      lp.wake_on_any_pending    <= PWDATA[WAKE_ANY_BIT];
      lp.low_power_depth_select <= PWDATA[DEPTH_BIT];
      lp.nap_after_last_handler <= PWDATA[NAP_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Captured in the setup cycle so PRDATA is a flop in the access cycle.
  // key readback
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_exc) begin
      next_rdata[31:KEY_LSB]      = UNLOCK_READBACK_VALUE;
      next_rdata[ENDIAN_BIT]      = ENDIAN_LITTLE;
      next_rdata[SPLIT_LSB +: 3]  = priority_split_point;
    end else if (hit_lp) begin
      next_rdata[WAKE_ANY_BIT]    = lp.wake_on_any_pending;
      next_rdata[DEPTH_BIT]       = lp.low_power_depth_select;
      next_rdata[NAP_BIT]         = lp.nap_after_last_handler;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_en) begin
      PRDATA <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // External event synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= EXT_EVENT;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  assign ext_rise = ext_sync & ~ext_prev;

  // ----------------------------------------------------------------------
  // Wake sources and event latch
  // ----------------------------------------------------------------------
  // disabled irq gate
  assign wake_src = IRQ_PEND_ENABLED | EVENT_PULSE | SEND_EVENT_INSTR | ext_rise |
                    (lp.wake_on_any_pending & IRQ_PEND_DISABLED);

  // A new event in the consuming cycle does not set the latch again: clear wins.
  // latch pending event
  always_comb begin
    next_latch = event_latch;
    if (WAIT_FOR_EVENT_INSTR && state == ERSC_RUN) begin
      next_latch = 1'b0;
    end
    if (state == ERSC_WAIT) begin
      next_latch = 1'b0;
    end
    if (wake_src && state == ERSC_RUN && !WAIT_FOR_EVENT_INSTR) begin
      next_latch = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      event_latch <= 1'b0;
    end else begin
      event_latch <= next_latch;
    end
  end

  // ----------------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------------
  // wake from wait
  always_comb begin
    next_state = state;
    case (state)
      ERSC_RUN: begin
        if (WAIT_FOR_EVENT_INSTR && !event_latch && !wake_src) begin
          next_state = ERSC_WAIT;
        end else if (LAST_HANDLER_RETURN && lp.nap_after_last_handler) begin
          next_state = ERSC_SLEEP;
        end
      end
      ERSC_WAIT: begin
        if (wake_src) begin
          next_state = ERSC_RUN;
        end
      end
      ERSC_SLEEP: begin
        if (wake_src) begin
          next_state = ERSC_RUN;
        end
      end
      default: begin
        next_state = ERSC_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state <= ERSC_RUN;
    end else begin
      state <= next_state;
    end
  end

  assign CORE_WAITING    = (state != ERSC_RUN);
  assign CORE_SLEEP      = (state != ERSC_RUN) & ~lp.low_power_depth_select;
  assign CORE_DEEP_SLEEP = (state != ERSC_RUN) & lp.low_power_depth_select;

  // ----------------------------------------------------------------------
  // Preemption comparator
  // ----------------------------------------------------------------------
  // Packed here so the comparator port sees a plain net of the struct type.
  assign prio_pair = '{prio_a: PRIO_A, prio_b: PRIO_B};

  ersc_preempt u_preempt (
    .CLK     (CLK),
    .RST_N   (RST_N),
    .split   (priority_split_point),
    .pair    (prio_pair),
    .preempt (PREEMPT)
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // Register checks look one cycle after the committing edge, because every
  // field and the read data come out of flops.
  a_key_bad_write: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_en && hit_exc && !key_ok) |=> $stable(priority_split_point))
    else $error("split point changed without key");

  a_key_bad_reset: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_en && hit_exc && !key_ok) |=> !WHOLE_SYSTEM_RESET_REQUEST)
    else $error("reset request without key");

  a_readback_key: assert property (@(posedge CLK) disable iff (!RST_N)
    (rd_en && hit_exc) |=> (PRDATA[31:KEY_LSB] == UNLOCK_READBACK_VALUE && !PRDATA[ENDIAN_BIT]))
    else $error("bad key readback or endian");

  a_low_bits_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    (rd_en && hit_exc) |=> (PRDATA[2:0] == 3'h0))
    else $error("exception config low bits nonzero");

  a_split_update: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_en && hit_exc && key_ok) |=> (priority_split_point == $past(PWDATA[SPLIT_LSB +: 3])))
    else $error("split point not written");

  a_split_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    !(wr_en && hit_exc) |=> $stable(priority_split_point))
    else $error("split point changed without a write");

  a_reset_req: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_en && hit_exc && key_ok && PWDATA[RESET_REQ_BIT]) |=> WHOLE_SYSTEM_RESET_REQUEST ##1
    !WHOLE_SYSTEM_RESET_REQUEST || (wr_en && hit_exc))
    else $error("reset request not pulsed");

  a_reset_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_en && hit_exc && key_ok && !PWDATA[RESET_REQ_BIT]) |=> !WHOLE_SYSTEM_RESET_REQUEST)
    else $error("reset request without bit set");

  a_disabled_nowake: assert property (@(posedge CLK) disable iff (!RST_N)
    (state == ERSC_WAIT && !lp.wake_on_any_pending && !IRQ_PEND_ENABLED && !EVENT_PULSE
     && !SEND_EVENT_INSTR && !ext_rise) |=> (state == ERSC_WAIT))
    else $error("woke without a wake source");

  a_disabled_wake: assert property (@(posedge CLK) disable iff (!RST_N)
    (state != ERSC_RUN && lp.wake_on_any_pending && IRQ_PEND_DISABLED) |=> (state == ERSC_RUN))
    else $error("disabled interrupt did not wake");

  a_enabled_wake: assert property (@(posedge CLK) disable iff (!RST_N)
    (state != ERSC_RUN && IRQ_PEND_ENABLED) |=> (state == ERSC_RUN))
    else $error("enabled interrupt did not wake");

  a_latch_set: assert property (@(posedge CLK) disable iff (!RST_N)
    (state == ERSC_RUN && wake_src && !WAIT_FOR_EVENT_INSTR) |=> event_latch)
    else $error("event not latched while running");

  // A handler return in the same cycle may still send the core to sleep.
  a_latched_wfe: assert property (@(posedge CLK) disable iff (!RST_N)
    (state == ERSC_RUN && event_latch && WAIT_FOR_EVENT_INSTR && !LAST_HANDLER_RETURN)
    |=> (state == ERSC_RUN))
    else $error("latched event did not skip wait");

  a_sev_wake: assert property (@(posedge CLK) disable iff (!RST_N)
    (state == ERSC_WAIT && SEND_EVENT_INSTR) |=> (state == ERSC_RUN))
    else $error("send event did not wake");

  a_ext_wake: assert property (@(posedge CLK) disable iff (!RST_N)
    (state == ERSC_WAIT && ext_rise) |=> (state == ERSC_RUN))
    else $error("external event did not wake");

  a_depth_out: assert property (@(posedge CLK) disable iff (!RST_N)
    CORE_WAITING |-> (CORE_DEEP_SLEEP == lp.low_power_depth_select))
    else $error("wrong sleep depth");

  a_depth_one_hot: assert property (@(posedge CLK) disable iff (!RST_N)
    !(CORE_SLEEP && CORE_DEEP_SLEEP))
    else $error("both sleep depths shown");

  a_depth_write: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_en && hit_lp) |=> (lp.low_power_depth_select == $past(PWDATA[DEPTH_BIT])))
    else $error("depth bit not written");

  a_nap_write: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_en && hit_lp) |=> (lp.nap_after_last_handler == $past(PWDATA[NAP_BIT])))
    else $error("nap bit not written");

  a_nap_exit: assert property (@(posedge CLK) disable iff (!RST_N)
    (state == ERSC_RUN && LAST_HANDLER_RETURN && !WAIT_FOR_EVENT_INSTR)
    |=> (CORE_WAITING == $past(lp.nap_after_last_handler)))
    else $error("sleep on exit mismatch");

  a_lp_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    !(wr_en && hit_lp) |=> $stable(lp))
    else $error("low-power bits changed without a write");

  a_lp_reserved: assert property (@(posedge CLK) disable iff (!RST_N)
    (rd_en && hit_lp) |=> (PRDATA[31:5] == 27'h0 && !PRDATA[3] && !PRDATA[0]))
    else $error("reserved low-power bits nonzero");

endmodule

// File: verification/ersc_sys_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Outer system reset controller
// ----------------------------------------------------------------------
// Counts reset requests instead of restarting the system, so that the
// bench keeps running and can compare the count after each request.
module ersc_sys_model (
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic req,
  output int        resets
);
  logic req_q;

  // request counted here.
  // A long request still counts once, because only its rising edge is taken.
  always_ff @(posedge CLK) begin
    req_q <= req;
    if (!RST_N) begin
      resets <= 0;
    end else if (req && !req_q) begin
      resets <= resets + 1;
    end
  end
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import ersc_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, preempt;
  logic        rst_req, waiting, sleep, deep;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [7:0]  prio_a, prio_b;
  logic [6:0]  ev;
  logic [33:0] e;
  logic [33:0] exp_q[$];
  int          n_errors, n_checks, resets;
  localparam logic [6:0] P_EN = 7'h40, P_DIS = 7'h20, P_EVT = 7'h10, P_EXT = 7'h08;
  localparam logic [6:0] P_SEV = 7'h04, P_WFE = 7'h02, P_LHR = 7'h01;

  ersc_top uut (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PRIO_A(prio_a), .PRIO_B(prio_b), .PREEMPT(preempt),
    .IRQ_PEND_ENABLED(ev[6]), .IRQ_PEND_DISABLED(ev[5]), .EVENT_PULSE(ev[4]),
    .EXT_EVENT(ev[3]), .SEND_EVENT_INSTR(ev[2]), .WAIT_FOR_EVENT_INSTR(ev[1]),
    .LAST_HANDLER_RETURN(ev[0]), .WHOLE_SYSTEM_RESET_REQUEST(rst_req),
    .CORE_WAITING(waiting), .CORE_SLEEP(sleep), .CORE_DEEP_SLEEP(deep)
  );
  ersc_sys_model sys (.CLK(clk), .RST_N(rst_n), .req(rst_req), .resets(resets));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] x);
    n_checks++;
    if (got !== x) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, x);
    end
  endtask

  task automatic check_pw(input logic [2:0] x);
    check_val({29'h0, waiting, sleep, deep}, {29'h0, x});
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] exp_exc(input logic [2:0] g);
    return {UNLOCK_READBACK_VALUE, ENDIAN_LITTLE, 4'h0, g, 8'h00};
  endfunction

  // One APB transfer; the expected answer is queued for the monitor.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] x);
    int i;
    exp_q.push_back({!w, (a != ADDR_EXC_CFG && a != ADDR_LOW_POWER), x});
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      stop_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // One-cycle pulse on the power inputs, then one cycle for the state to land.
  task automatic pulse(input logic [6:0] b);
    @(posedge clk);
    ev <= b;
    @(posedge clk);
    ev <= 7'h00;
    @(posedge clk);
  endtask

  // Completed transfers are matched against the oldest expectation.
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check_val(32'h1, 32'h0);
      end else begin
        e = exp_q.pop_front();
        check_val({31'h0, pslverr}, {31'h0, e[32]});
        if (e[33]) check_val(prdata, e[31:0]);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    int g, j, i, n;
    logic [31:0] r;
    logic [7:0] mask;
    {rst_n, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata, prio_a, prio_b, ev} = '0;
    seed = 32'h0000002D;
    n_errors = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_EXC_CFG, 0, exp_exc(SPLIT_RESET));
    apb(1'b0, ADDR_LOW_POWER, 0, 0);
    apb(1'b1, 12'h008, 32'hFFFFFFFF, 0);
    apb(1'b0, 12'h008, 0, 0);
    // every split point, random reserved bits written.
    for (g = 0; g < 8; g++) begin
      r = rnd();
      apb(1'b1, ADDR_EXC_CFG, {UNLOCK_KEY_VALUE, r[15:11], g[2:0], r[7:3], 3'h0}, 0);
      apb(1'b0, ADDR_EXC_CFG, 0, exp_exc(g[2:0]));
      mask = (g == 7) ? 8'h00 : 8'hFF << (g + 1);
      // The first pair differs only in subpriority and never preempts.
      for (j = 0; j < 4; j++) begin
        r = rnd();
        @(posedge clk);
        prio_a <= r[7:0];
        prio_b <= (j == 0) ? (r[7:0] ^ ~mask) : r[15:8];
        repeat (2) @(posedge clk);
        check_val(preempt, (r[7:0] & mask) < (prio_b & mask));
      end
    end
    n = resets;
    apb(1'b1, ADDR_EXC_CFG, 32'h05FB0104, 0);
    apb(1'b0, ADDR_EXC_CFG, 0, exp_exc(3'h7));
    check_val(resets, n);
    apb(1'b1, ADDR_EXC_CFG, {UNLOCK_KEY_VALUE, 16'h0704}, 0);
    apb(1'b0, ADDR_EXC_CFG, 0, exp_exc(3'h7));
    repeat (2) @(posedge clk);
    check_val(resets, n + 1);
    apb(1'b1, ADDR_LOW_POWER, 32'hFFFFFFFF, 0);
    apb(1'b0, ADDR_LOW_POWER, 0, 32'h00000016);
    apb(1'b1, ADDR_LOW_POWER, 0, 0);
    pulse(P_WFE);
    check_pw(3'h6);
    pulse(P_DIS);
    check_pw(3'h6);
    pulse(P_EN);
    check_pw(3'h0);
    apb(1'b1, ADDR_LOW_POWER, 32'h00000014, 0);
    pulse(P_WFE);
    check_pw(3'h5);
    pulse(P_DIS);
    check_pw(3'h0);
    pulse(P_EVT);
    pulse(P_WFE);
    check_pw(3'h0);
    pulse(P_WFE);
    check_pw(3'h5);
    pulse(P_SEV);
    check_pw(3'h0);
    pulse(P_WFE);
    pulse(P_EXT);
    for (i = 0; i < 8 && waiting !== 1'b0; i++) @(posedge clk);
    check_pw(3'h0);
    apb(1'b1, ADDR_LOW_POWER, 32'h00000002, 0);
    pulse(P_LHR);
    check_pw(3'h6);
    pulse(P_EN);
    apb(1'b1, ADDR_LOW_POWER, 0, 0);
    pulse(P_LHR);
    check_pw(3'h0);
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule
